/* File: rtl/dbw_pkg.sv */
/*
 * Shared constants and carrier types of the breakpoint and watchpoint unit.
 * Assumes a 32-bit core with byte addressed registers on a plain port.
 */
`default_nettype none
package dbw_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_PC_ADDR  = 8'h00; // Six words
    localparam logic [7:0] OFS_PC_CTRL  = 8'h20; // Six words
    localparam logic [7:0] OFS_D_ADDR   = 8'h40; // Two words
    localparam logic [7:0] OFS_D_CTRL   = 8'h48; // Two words
    localparam logic [7:0] OFS_D_VAL    = 8'h50; // Two words
    localparam logic [7:0] OFS_PAIR     = 8'h58;
    localparam logic [7:0] OFS_DBG_CTRL = 8'h5C;
    localparam logic [7:0] OFS_STATUS   = 8'h60;
    localparam logic [7:0] OFS_RET_ADDR = 8'h64;
    localparam logic [7:0] OFS_RET_STAT = 8'h68;

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int EN_HI   = 31;
    localparam int EN_LO   = 30;
    localparam int RNG_HI  = 27; // Pair range, PC A modules only
    localparam int RNG_LO  = 26;
    localparam int ADDRESS_MASK_ENABLE     = 25;
    localparam int VAL_EN  = 22; // Data value compare enable
    localparam int SZ_EN   = 21;
    localparam int SZ_HI   = 20;
    localparam int SZ_LO   = 19;
    localparam int BM_HI   = 18;
    localparam int BM_LO   = 15;
    localparam int EOC     = 14;
    localparam int ASID_HI = 8;
    localparam int ASID_LO = 1;
    localparam int ASID_EN = 0;
    localparam int DOUBLE_WORD_ENABLE     = 2;
    localparam int EOS_HI  = 1;
    localparam int EOS_LO  = 0;
    localparam int IGNORE_FIRST_MATCH     = 2;

    // ************************************************************
    // Codes and reset values
    // ************************************************************
    localparam logic [1:0]  EN_OFF    = 2'h0;
    localparam logic [1:0]  EN_BRK    = 2'h1;
    localparam logic [1:0]  EN_WP     = 2'h3;
    localparam logic [1:0]  RNG_OFF   = 2'h0;
    localparam logic [1:0]  RNG_EXC   = 2'h1;
    localparam logic [1:0]  RNG_INC   = 2'h2;
    localparam logic [1:0]  EOS_ON    = 2'h1;
    localparam logic [1:0]  SZ_BYTE   = 2'h0;
    localparam logic [1:0]  SZ_HALF   = 2'h1;
    localparam logic [1:0]  SZ_WORD   = 2'h2;
    localparam logic [1:0]  SZ_DWORD  = 2'h3;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam int          N_PC      = 6;
    localparam int          N_DATA    = 2;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } dbw_bus_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
    } dbw_fetch_type;

    typedef struct packed {
        logic        valid;
        logic        ldst;  // Genuine load or store, not cache traffic
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [63:0] data;  // Memory lanes, word 1 in the upper half
    } dbw_dacc_type;

    typedef struct packed {
        logic        debug_mode;
        logic        monitor_mode;
        logic [7:0]  asid;
        logic [31:0] sr;
    } dbw_cpu_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] hit;
    } dbw_wh_type;

    typedef struct packed {
        logic       valid;
        logic [1:0] hit;
    } dbw_twh_type;
endpackage
`default_nettype wire

/* File: rtl/dbw_unit.sv */
/*
 * Breakpoint and watchpoint unit: six PC comparators, two data comparators,
 * hit messages, event pin and halt request with return address capture.
 * Assumes fetch, data and CPU inputs synchronous to i_clk.
 */
`default_nettype none
module dbw_unit (
    // Clock, reset, enable
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,
    // Register port
    input  wire dbw_pkg::dbw_bus_type  i_bus,
    output logic [31:0]                o_rdata,
    // Core snoop
    input  wire dbw_pkg::dbw_fetch_type i_fetch,
    input  wire dbw_pkg::dbw_dacc_type i_dacc,
    input  wire dbw_pkg::dbw_cpu_type  i_cpu,
    input  wire logic [1:0]            i_trace_wp,
    // Messages and halt
    output dbw_pkg::dbw_wh_type        o_wh,
    output dbw_pkg::dbw_twh_type       o_twh,
    output logic                       o_evt_out,
    output logic                       o_halt,
    output logic [31:0]                o_ret_addr,
    output logic [31:0]                o_ret_stat,
    output logic [7:0]                 o_status
);
    import dbw_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // ASID qualifier shared by all eight modules
    function automatic logic asid_ok(input logic [31:0] c, input logic [7:0] a);
        asid_ok = ~c[ASID_EN] | (c[ASID_HI:ASID_LO] == a);
    endfunction

    // Pair range test, A bound exclusive below, B bound inclusive above
    function automatic logic in_rng(input logic [31:0] x, input logic [31:0] lo,
                                    input logic [31:0] hi, input logic [1:0] r);
        in_rng = (r == RNG_INC) ? (x > lo && x <= hi) :
                 (r == RNG_EXC) ? (x <= lo || x > hi) : 1'b0;
    endfunction

    // Register block index from a byte address
    function automatic logic [2:0] widx(input logic [7:0] a, input logic [7:0] b);
        widx = 3'((a - b) >> 2);
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0] pa_q [N_PC];
    logic [31:0] pc_q [N_PC];
    logic [31:0] da_q [N_DATA];
    logic [31:0] dc_q [N_DATA];
    logic [31:0] dv_q [N_DATA];
    logic [2:0]  pair_q;
    logic [2:0]  dbg_q;
    logic [7:0]  stat_q;
    logic [31:0] rtad_q;
    logic [31:0] rtst_q;
    logic [31:0] rdat_q;
    logic        dm_q;
    logic        first_q;
    logic        dpend_q;
    logic [1:0]  dsrc_q;
    dbw_wh_type  wh_q;
    dbw_twh_type twh_q;
    logic        evt_q;
    logic        halt_q;

    // Write decode
    wire         wr_w    = i_ce & i_bus.wr;
    wire  [7:0]  ba_w    = i_bus.addr;
    wire  [2:0]  ipa_w   = widx(ba_w, OFS_PC_ADDR);
    wire  [2:0]  ipc_w   = widx(ba_w, OFS_PC_CTRL);
    wire  [2:0]  ida_w   = widx(ba_w, OFS_D_ADDR);
    wire  [2:0]  idc_w   = widx(ba_w, OFS_D_CTRL);
    wire  [2:0]  idv_w   = widx(ba_w, OFS_D_VAL);
    wire         s_pa_w  = ba_w >= OFS_PC_ADDR && ba_w < OFS_PC_CTRL - 8'h08;
    wire         s_pc_w  = ba_w >= OFS_PC_CTRL && ba_w < OFS_D_ADDR - 8'h08;
    wire         s_da_w  = ba_w >= OFS_D_ADDR && ba_w < OFS_D_CTRL;
    wire         s_dc_w  = ba_w >= OFS_D_CTRL && ba_w < OFS_D_VAL;
    wire         s_dv_w  = ba_w >= OFS_D_VAL && ba_w < OFS_PAIR;

    // Configuration stores; last word addresses outside blocks are ignored
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < N_PC; i++) begin
                pa_q[i] <= RST_WORD;
                pc_q[i] <= RST_WORD;
            end
            for (int i = 0; i < N_DATA; i++) begin
                da_q[i] <= RST_WORD;
                dc_q[i] <= RST_WORD;
                dv_q[i] <= RST_WORD;
            end
            pair_q <= 3'h0;
            dbg_q  <= 3'h0;
        end else if (wr_w) begin
            if (s_pa_w) pa_q[ipa_w] <= i_bus.wdata;
            if (s_pc_w) pc_q[ipc_w] <= i_bus.wdata;
            if (s_da_w) da_q[ida_w[0]] <= i_bus.wdata;
            if (s_dc_w) dc_q[idc_w[0]] <= i_bus.wdata;
            if (s_dv_w) dv_q[idv_w[0]] <= i_bus.wdata;
            if (ba_w == OFS_PAIR) pair_q <= i_bus.wdata[2:0];
            if (ba_w == OFS_DBG_CTRL) dbg_q <= i_bus.wdata[2:0];
        end
    end

    // ************************************************************
    // Program counter comparators
    // ************************************************************
    wire       act_w   = ~i_cpu.debug_mode;
    wire       exit_w  = dm_q & ~i_cpu.debug_mode;
    wire       sup_w   = first_q | (exit_w & dbg_q[IGNORE_FIRST_MATCH]);
    wire       fv_w    = i_fetch.valid & act_w;
    logic [5:0] phit_w;

    // Pair p uses modules 2p (A) and 2p+1 (B)
    for (genvar p = 0; p < 3; p++) begin : g_pair
        wire [31:0] ca  = pc_q[2*p];
        wire [31:0] cb  = pc_q[2*p+1];
        wire [31:0] aa  = pa_q[2*p];
        wire [31:0] ab  = pa_q[2*p+1];
        wire [1:0]  range_select = ca[RNG_HI:RNG_LO];
        wire        rg  = range_select != RNG_OFF;
        wire        msk = (i_fetch.pc & ab) == (aa & ab);
        wire        ma  = ca[ADDRESS_MASK_ENABLE] ? msk :
                          rg ? in_rng(i_fetch.pc, aa, ab, range_select) : i_fetch.pc == aa;
        assign phit_w[2*p]   = fv_w & asid_ok(ca, i_cpu.asid) & ma;
        assign phit_w[2*p+1] = fv_w & asid_ok(cb, i_cpu.asid) & ~ca[ADDRESS_MASK_ENABLE] & ~rg
                               & (i_fetch.pc == ab);
    end

    // ************************************************************
    // Data comparators
    // ************************************************************
    wire        dv_w   = i_dacc.valid & i_dacc.ldst & act_w
                         & ~i_cpu.monitor_mode;
    wire [1:0]  drng_w = pair_q[1:0];
    wire        drg_w  = drng_w != RNG_OFF;
    wire        dwe_w  = pair_q[DOUBLE_WORD_ENABLE];
    logic [1:0] dm_w;

    for (genvar d = 0; d < N_DATA; d++) begin : g_data
        wire [31:0] c    = dc_q[d];
        wire [31:0] a    = da_q[d];
        // Word of a double word chosen by the stored address
        wire [31:0] wrd  = a[2] ? i_dacc.data[63:32] : i_dacc.data[31:0];
        wire [31:0] sh   = wrd >> {a[1:0], 3'h0};
        wire [31:0] bm   = {{8{~c[BM_LO+3]}}, {8{~c[BM_LO+2]}},
                            {8{~c[BM_LO+1]}}, {8{~c[BM_LO]}}};
        wire        vok  = ~c[VAL_EN] | ((sh & bm) == (dv_q[d] & bm));
        wire        sok  = ~c[SZ_EN] | (c[SZ_HI:SZ_LO] == i_dacc.size);
        // Address hit when the stored byte lies inside the aligned access
        wire [31:0] am   = (i_dacc.size == SZ_DWORD) ? 32'hFFFF_FFF8 :
                           (i_dacc.size == SZ_WORD)  ? 32'hFFFF_FFFC :
                           (i_dacc.size == SZ_HALF)  ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
        wire        aok  = (a & am) == (i_dacc.addr & am);
        assign dm_w[d]   = dv_w & asid_ok(c, i_cpu.asid) & vok & sok & aok;
    end

    // Range mode replaces A's whole match, value and size tests included; B only feeds A
    wire        dra_w  = dv_w & asid_ok(dc_q[0], i_cpu.asid)
                         & in_rng(i_dacc.addr, da_q[0], da_q[1], drng_w);
    wire        dha_w  = drg_w ? dra_w :
                         dwe_w ? dm_w[0] & dm_w[1] : dm_w[0];
    wire        dhb_w  = dm_w[1] & ~dwe_w & ~drg_w;
    wire [1:0]  dhit_w = {dhb_w, dha_w};

    // ************************************************************
    // Event classification
    // ************************************************************
    logic [7:0] brk_w;
    logic [7:0] wp_w;
    logic [7:0] eoc_w;
    wire  [7:0] hit_w  = {dhit_w, phit_w};

    for (genvar m = 0; m < 8; m++) begin : g_kind
        // Split by generate so no branch indexes outside its array
        wire [31:0] c;
        if (m < N_PC) begin : g_pc
            assign c = pc_q[m];
        end else begin : g_dt
            assign c = dc_q[m - N_PC];
        end
        assign brk_w[m] = hit_w[m] & (c[EN_HI:EN_LO] == EN_BRK);
        assign wp_w[m]  = hit_w[m] & (c[EN_HI:EN_LO] == EN_WP);
        assign eoc_w[m] = hit_w[m] & c[EOC] & (c[EN_HI:EN_LO] != EN_OFF);
    end

    wire  [7:0] pbrk_w = {2'h0, brk_w[5:0] & {6{~sup_w}}};
    wire  [1:0] dbrk_w = brk_w[7:6];
    wire        pany_w = |pbrk_w;
    wire        dfire_w = dpend_q & fv_w;
    wire        halt_w = pany_w | dfire_w;
    wire        wh_w   = |wp_w;
    wire        eos_w  = dbg_q[EOS_HI:EOS_LO] == EOS_ON;

    // ************************************************************
    // Sequencing and outputs
    // ************************************************************
    // Ignore-first-match window; the first fetch after exit consumes it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dm_q    <= 1'b0;
            first_q <= 1'b0;
        end else if (i_ce) begin
            dm_q    <= i_cpu.debug_mode;
            first_q <= sup_w & ~fv_w;
        end
    end

    // Data breakpoint waits for the following instruction
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dpend_q <= 1'b0;
            dsrc_q  <= 2'h0;
        end else if (i_ce) begin
            dpend_q <= (|dbrk_w) | (dpend_q & ~fv_w & act_w);
            dsrc_q  <= (|dbrk_w) ? dbrk_w : (dfire_w ? 2'h0 : dsrc_q);
        end
    end

    // Halt, return capture and sticky source; new hit wins over clearing
    wire [7:0] sset_w = {dfire_w ? dsrc_q : 2'h0, pbrk_w[5:0]};
    wire [7:0] sclr_w = (wr_w && ba_w == OFS_STATUS) ? i_bus.wdata[7:0] : 8'h00;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            halt_q <= 1'b0;
            rtad_q <= RST_WORD;
            rtst_q <= RST_WORD;
            stat_q <= 8'h00;
        end else if (i_ce) begin
            halt_q <= halt_w;
            if (halt_w) rtad_q <= i_fetch.pc;
            if (halt_w) rtst_q <= i_cpu.sr;
            stat_q <= (stat_q & ~sclr_w) | sset_w;
        end
    end

    // Messages and event pin, one cycle each
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wh_q  <= '0;
            twh_q <= '0;
            evt_q <= 1'b0;
        end else if (i_ce) begin
            wh_q  <= '{valid: wh_w, hit: wp_w};
            twh_q <= '{valid: |i_trace_wp & ~wh_w & act_w,
                       hit: (wh_w | ~act_w) ? 2'h0 : i_trace_wp};
            evt_q <= eos_w & (|eoc_w);
        end
    end

    // ************************************************************
    // Read back
    // ************************************************************
    logic [31:0] rd_w;
    always_comb begin
        rd_w = 32'h0000_0000;
        if (s_pa_w) rd_w = pa_q[ipa_w];
        else if (s_pc_w) rd_w = pc_q[ipc_w];
        else if (s_da_w) rd_w = da_q[ida_w[0]];
        else if (s_dc_w) rd_w = dc_q[idc_w[0]];
        else if (s_dv_w) rd_w = dv_q[idv_w[0]];
        else if (ba_w == OFS_PAIR) rd_w = {29'h0, pair_q};
        else if (ba_w == OFS_DBG_CTRL) rd_w = {29'h0, dbg_q};
        else if (ba_w == OFS_STATUS) rd_w = {24'h0, stat_q};
        else if (ba_w == OFS_RET_ADDR) rd_w = rtad_q;
        else if (ba_w == OFS_RET_STAT) rd_w = rtst_q;
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) rdat_q <= RST_WORD;
        else if (i_ce) rdat_q <= i_bus.rd ? rd_w : RST_WORD;
    end

    assign o_rdata    = rdat_q;
    assign o_wh       = wh_q;
    assign o_twh      = twh_q;
    assign o_evt_out  = evt_q;
    assign o_halt     = halt_q;
    assign o_ret_addr = rtad_q;
    assign o_ret_stat = rtst_q;
    assign o_status   = stat_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_dacc_brk;
        i_ce && (|dbrk_w) && !pany_w && !dpend_q;
    endsequence
    sequence s_next_fetch;
        i_ce && dpend_q && fv_w;
    endsequence

    AST_DBG_QUIET: assert property (i_ce && i_cpu.debug_mode |=> !o_wh.valid && !o_halt)
        else $error("Match seen in debug mode");
    AST_IFM_SKIP: assert property (i_ce && sup_w && fv_w && !dpend_q |=> !o_halt)
        else $error("Breakpoint on ignored first instruction");
    AST_EVT_SEL: assert property (i_ce && !eos_w |=> !o_evt_out)
        else $error("Event pin pulsed without select");
    AST_TWH_DROP: assert property (i_ce && wh_w |=> !o_twh.valid)
        else $error("Trace hit kept beside watchpoint hit");
    AST_HALT_RET: assert property (i_ce && pany_w |=> o_halt && o_ret_addr == $past(i_fetch.pc))
        else $error("Halt or return address missing");
    AST_MON_NODATA: assert property (i_ce && i_cpu.monitor_mode |=> o_wh.hit[7:6] == 2'h0)
        else $error("Data watchpoint in monitor mode");
    AST_AME_B: assert property (i_ce && pc_q[0][ADDRESS_MASK_ENABLE] |=> !o_wh.hit[1])
        else $error("Masked pair B module hit");
    AST_DATA_DEFER: assert property (s_dacc_brk |=> !o_halt && dpend_q)
        else $error("Data breakpoint halted on the access");
    AST_DATA_NEXT: assert property (s_next_fetch |=> o_halt && o_status[7:6] != 2'h0)
        else $error("Deferred data halt missing");
    AST_RANGE_B: assert property (i_ce && drg_w |=> !o_wh.hit[7])
        else $error("Range B module hit");
    AST_DWE_BOTH: assert property (i_ce && dwe_w && !drg_w && !dm_w[1] |=> !o_wh.hit[6])
        else $error("Double word hit without B match");
    // A ranged PC pair leaves its B module mute
    AST_PC_RANGE_B: assert property (i_ce && pc_q[0][RNG_HI:RNG_LO] != RNG_OFF |=> !o_wh.hit[1])
        else $error("Ranged pair B module hit");
    // Trace hits are silenced with the comparators while debugging
    AST_TWH_DBG: assert property (i_ce && i_cpu.debug_mode |=> !o_twh.valid)
        else $error("Trace hit seen in debug mode");
endmodule
`default_nettype wire

/* File: verif/dbw_core_model.sv */
/*
 * Core model: takes the halt pulse and stays in debug mode for a while.
 * Assumes the halt request is a one-cycle pulse on i_clk.
 */
`default_nettype none
module dbw_core_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Halt request and residence time
    input  wire logic       i_halt,
    input  wire logic [7:0] i_dbg_len,
    output logic            o_debug_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    // A second halt during debug is ignored, as a real core would be halted already
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 8'h00;
        end else if (i_halt && cnt_q == 8'h00) begin
            cnt_q <= i_dbg_len;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    assign o_debug_mode = (cnt_q != 8'h00);
endmodule
`default_nettype wire

/* File: verif/tb_dbw_unit.sv */
/*
 * Self-checking bench of the breakpoint unit.
 * Assumes the core model is compiled before it.
 */
`default_nettype none
module tb_dbw_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import dbw_pkg::*;
    // ****************
    // Signals
    // ****************
    logic          i_clk;
    logic          i_rst_n = 1'b0;
    dbw_bus_type   bus = '0;
    dbw_fetch_type fe = '0;
    dbw_dacc_type  da = '0;
    dbw_cpu_type   cpu;
    dbw_wh_type    wh;
    dbw_twh_type   twh;
    logic [31:0]   rdat, rad, rst, r, p, v;
    logic [31:0]   sd = 32'd51941;
    logic [31:0]   sr = '0;
    logic [7:0]    sts, len;
    logic [7:0]    asid = '0;
    logic [1:0]    tw = '0;
    logic          evt, hlt, dbg;
    logic          mon = 1'b0;
    int            n_fail = 0;
    int            check_count = 0;
    int            i;
    assign cpu = {dbg, mon, asid, sr};
    dbw_unit dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_bus(bus), .o_rdata(rdat),
        .i_fetch(fe), .i_dacc(da), .i_cpu(cpu), .i_trace_wp(tw), .o_wh(wh), .o_twh(twh),
        .o_evt_out(evt), .o_halt(hlt), .o_ret_addr(rad), .o_ret_stat(rst), .o_status(sts));
    dbw_core_model core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_halt(hlt), .i_dbg_len(len),
        .o_debug_mode(dbg));
    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] ctl(input logic [1:0] en, input logic [31:0] x);
        return (32'(en) << EN_LO) | x;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk) bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk) bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge i_clk) bus.rd <= 1'b0;
        #1 d = rdat;
    endtask
    // Outputs are looked at just after the edge that sampled the fetch
    task automatic fet(input logic [31:0] pc, input logic [1:0] t);
        @(posedge i_clk) fe <= '{1'b1, pc};
        tw <= t;
        @(posedge i_clk) fe.valid <= 1'b0;
        tw <= 2'b00;
        #1;
    endtask
    // Bounded wait for the core model to leave debug mode
    task automatic run;
        int k;
        k = 0;
        @(posedge i_clk) #1;
        while (dbg !== 1'b0 && k < 60) begin
            @(posedge i_clk) #1;
            k++;
        end
        if (k == 60) begin
            n_fail++;
            give_verdict();
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    initial begin
        len = 8'h02 + 8'(xs(sd) & 32'h7);
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1 chk("halt", 0, hlt);
        for (i = 0; i < N_PC; i++) begin
            rd(OFS_PC_ADDR + 8'(4 * i), r);
            chk("rst", RST_WORD, r);
            sd = xs(sd);
            wr(OFS_PC_ADDR + 8'(4 * i), sd);
            rd(OFS_PC_ADDR + 8'(4 * i), r);
            chk("addr", sd, r);
        end
        wr(8'h18, sd);
        rd(8'h18, r);
        chk("unmapped", 0, r);
        for (i = 0; i < N_PC; i++) begin
            sd = xs(sd);
            sr = ~sd;
            wr(OFS_PC_ADDR + 8'(4 * i), sd);
            wr(OFS_PC_CTRL + 8'(4 * i), ctl(EN_BRK, 0));
            fet(sd, 2'b00);
            chk("halt", 1, hlt);
            chk("ret", sd, rad);
            chk("rstat", ~sd, rst);
            chk("sts", 32'h1 << i, sts);
            run();
            wr(OFS_PC_CTRL + 8'(4 * i), 0);
            wr(OFS_STATUS, 32'h0000_00FF);
        end
        // Ignore-first-match across a debug session
        p = xs(sd);
        wr(OFS_DBG_CTRL, 32'h0000_0004);
        wr(OFS_PC_ADDR, p);
        wr(OFS_PC_CTRL, ctl(EN_BRK, 0));
        fet(p, 2'b00);
        fet(p, 2'b00);
        chk("halt", 0, hlt);
        run();
        fet(p, 2'b00);
        chk("halt", 0, hlt);
        fet(p, 2'b00);
        chk("halt", 1, hlt);
        run();
        // Watchpoint on module 3 with event pin, trace hit alongside
        wr(OFS_PC_CTRL, 0);
        wr(OFS_DBG_CTRL, 32'(EOS_ON));
        wr(OFS_PC_ADDR + 8'h0C, p);
        wr(OFS_PC_CTRL + 8'h0C, ctl(EN_WP, 32'h0000_4000));
        fet(p, 2'b01);
        chk("wh", 9'h108, wh);
        chk("halt", 0, hlt);
        chk("evt", 1, evt);
        chk("twh", 0, twh.valid);
        wr(OFS_DBG_CTRL, 0);
        fet(p, 2'b10);
        chk("evt", 0, evt);
        fet(~p, 2'b10);
        chk("twh", 3'b110, twh);
        // ASID qualified breakpoint on module 2
        wr(OFS_PC_ADDR + 8'h08, p);
        wr(OFS_PC_CTRL + 8'h08, ctl(EN_BRK, 32'h0000_00B5));
        asid = 8'h5B;
        fet(p, 2'b00);
        chk("halt", 0, hlt);
        asid = 8'h5A;
        fet(p, 2'b00);
        chk("halt", 1, hlt);
        run();
        // Masked pair 2: B stays silent even with its own address fetched
        wr(OFS_PC_ADDR + 8'h10, 32'h1234_5678);
        wr(OFS_PC_ADDR + 8'h14, 32'hFFFF_0000);
        wr(OFS_PC_CTRL + 8'h14, ctl(EN_BRK, 0));
        wr(OFS_PC_CTRL + 8'h10, ctl(EN_BRK, 32'h0200_0000));
        fet(32'hFFFF_0000, 2'b00);
        chk("halt", 0, hlt);
        fet(32'h1234_ABCC, 2'b00);
        chk("halt", 1, hlt);
        run();
        // Inclusive PC range watchpoint on pair 0
        p = xs(p) & 32'hFFFF_FFF0;
        wr(OFS_PC_ADDR, p);
        wr(OFS_PC_ADDR + 8'h04, p + 32'h40);
        wr(OFS_PC_CTRL, ctl(EN_WP, 32'(RNG_INC) << RNG_LO));
        fet(p + 32'h40, 2'b00);
        chk("wh", 9'h101, wh);
        fet(p, 2'b00);
        chk("wh", 9'h000, wh);
        wr(OFS_PC_CTRL, 0);
        // Data byte match: cache traffic, monitor mode, wrong size, then a hit
        p = xs(p) & 32'hFFFF_FFF0;
        v = xs(p);
        wr(OFS_D_ADDR, p + 32'h1);
        wr(OFS_D_VAL, {24'h0, v[7:0]});
        for (i = 0; i < 4; i++) begin
            mon = (i == 1);
            wr(OFS_D_CTRL, ctl(EN_BRK, (i == 2) ? 32'h0067_0000 : 32'h0047_0000));
            @(posedge i_clk) da <= '{1'b1, i != 0, 1'b1, SZ_WORD, p, {v, v[31:16], v[7:0], v[15:8]}};
            @(posedge i_clk) da.valid <= 1'b0;
            #1 chk("halt", 0, hlt);
            fet(32'h0000_0100, 2'b00);
            chk("halt", i == 3, hlt);
        end
        chk("ret", 32'h0000_0100, rad);
        chk("sts", 1, sts[6]);
        run();
        // Data ranges, value compare off, B enabled yet silent
        wr(OFS_D_ADDR, p);
        wr(OFS_D_ADDR + 8'h04, p + 32'h10);
        wr(OFS_D_CTRL, ctl(EN_WP, 0));
        wr(OFS_D_CTRL + 8'h04, ctl(EN_WP, 0));
        for (i = 0; i < 4; i++) begin
            wr(OFS_PAIR, (i < 2) ? 32'(RNG_INC) : 32'(RNG_EXC));
            r = p + ((i == 0) ? 32'h10 : (i == 3) ? 32'h8 : 32'h0);
            @(posedge i_clk) da <= '{1'b1, 1'b1, 1'b0, SZ_WORD, r, 64'h0};
            @(posedge i_clk) da.valid <= 1'b0;
            #1 chk("wh", (i % 2 == 0) ? 9'h140 : 9'h000, wh);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
